// ==== rtl/pmc_power_mode_controller.sv ====
/*
 * Power mode controller: mode state machine, clock gates, oscillator, regulator,
 * power net and pin hold controls.
 * Assumes software follows the entry order and that mode writes arrive as pulses
 * on sys_clk; wake, reset and slow oscillator inputs are asynchronous pins.
 */
`include "pmc_consts.svh"

module pmc_power_mode_controller #(
	parameter int NUM_PERIPH = `PMC_NUM_PERIPH,
	parameter int SLOW_DIV   = `PMC_SLOW_DIV
) (
	input  logic                    sys_clk,
	input  logic                    srst,
	input  pmc_pkg::pmc_ctrl_a_s    mode_set_a,
	input  pmc_pkg::pmc_ctrl_b_s    mode_set_b,
	input  logic                    shutdown_select_bit,
	input  logic                    irq_any,
	input  logic [NUM_PERIPH-1:0]   periph_in_use,
	input  logic                    timer34_slow_sel,
	input  logic                    slow_osc,
	input  pmc_pkg::pmc_wake_s      wake_src,
	input  pmc_pkg::pmc_rst_s       rst_src,
	output pmc_pkg::pmc_ctrl_a_s    power_ctrl_reg_a,
	output pmc_pkg::pmc_ctrl_b_s    power_ctrl_reg_b,
	output pmc_pkg::pmc_state_e     mode_state,
	output logic                    core_clk_en,
	output logic [NUM_PERIPH-1:0]   periph_clk_en,
	output logic                    timer34_tick,
	output logic                    fast_osc_a_en,
	output logic                    fast_osc_b_en,
	output logic                    reg_low_bias,
	output logic                    power_nets_on,
	output logic                    pin_hold,
	output logic                    chip_reset,
	output logic                    core_resume
);
	import pmc_pkg::*;

	initial begin
		if (NUM_PERIPH < 1) begin
			$error("pmc_power_mode_controller: NUM_PERIPH must be at least 1");
		end
	end

	function automatic logic clocks_halted(input pmc_state_e s);
		return (s == st_suspend) || (s == st_snooze);
	endfunction

	function automatic logic nets_off(input pmc_state_e s);
		return (s == st_stop) || (s == st_shutdown);
	endfunction

	logic [`PMC_WAKE_W:0]   wake_vec;
	logic [`PMC_RST_W-1:0]  rst_vec;
	pmc_wake_s              wake_q;
	pmc_rst_s               rst_q;
	logic                   slow_q;
	logic                   cmp0_prev;
	logic                   cmp0_fall;
	logic                   wake_hit;

	pmc_state_e             state;
	pmc_state_e             next_state;
	pmc_ctrl_a_s            next_ctrl_a;
	pmc_ctrl_b_s            next_ctrl_b;
	logic                   next_core_clk_en;
	logic [NUM_PERIPH-1:0]  next_periph_clk_en;
	logic                   next_fast_osc_en;
	logic                   next_reg_low_bias;
	logic                   next_power_nets_on;
	logic                   next_pin_hold;
	logic                   next_chip_reset;
	logic                   next_core_resume;

	pmc_sync #(
		.WIDTH(`PMC_WAKE_W + 1)
	) u_wake_sync (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.async_in ({slow_osc, wake_src}),
		.sync_out (wake_vec)
	);

	pmc_sync #(
		.WIDTH(`PMC_RST_W)
	) u_rst_sync (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.async_in (rst_src),
		.sync_out (rst_vec)
	);

	// the slow tick keeps running in every mode with nets on
	pmc_slow_div #(
		.DIV(SLOW_DIV)
	) u_slow_div (
		.sys_clk    (sys_clk),
		.srst       (srst),
		.enable     (timer34_slow_sel & power_nets_on),
		.slow_level (slow_q),
		.tick       (timer34_tick)
	); // [R08]

	always_comb begin
		wake_q    = pmc_wake_s'(wake_vec[`PMC_WAKE_W-1:0]);
		slow_q    = wake_vec[`PMC_WAKE_W];
		rst_q     = pmc_rst_s'(rst_vec);
		cmp0_fall = cmp0_prev & ~wake_q.cmp0_level;
		wake_hit  = wake_q.timer4_event | wake_q.serial_periph_port_act
			| wake_q.two_wire_slave_port_act | wake_q.port_match
			| cmp0_fall | wake_q.config_logic_unit_irq; // [R09]
	end

	always_comb begin
		next_state       = state;
		next_ctrl_a      = power_ctrl_reg_a;
		next_ctrl_b      = power_ctrl_reg_b;
		next_chip_reset  = 1'b0;
		next_core_resume = 1'b0;
		case (state)
			st_normal: begin
				// a request set never loses against a clear; clears happen only off normal
				next_ctrl_a = power_ctrl_reg_a | mode_set_a;
				next_ctrl_b = power_ctrl_reg_b | mode_set_b;
				if (mode_set_a.stop) begin
					next_state = shutdown_select_bit ? st_shutdown : st_stop; // [R10] [R11]
				end else if (mode_set_b.snooze) begin
					next_state = st_snooze; // [R06]
				end else if (mode_set_b.suspend) begin
					next_state = st_suspend; // [R05]
				end else if (mode_set_a.idle) begin
					next_state = st_idle; // [R03]
				end
			end
			st_idle: begin
				if (irq_any) begin
					next_state       = st_normal;
					next_ctrl_a.idle = 1'b0; // [R13]
					next_core_resume = 1'b1; // [R04]
				end
			end
			st_suspend: begin
				if (wake_hit) begin
					next_state          = st_normal;
					next_ctrl_b.suspend = 1'b0; // [R13]
					next_core_resume    = 1'b1; // [R04]
				end
			end
			st_snooze: begin
				if (wake_hit) begin
					next_state         = st_normal;
					next_ctrl_b.snooze = 1'b0; // [R13]
					next_core_resume   = 1'b1; // [R04]
				end
			end
			st_stop: begin
				if (rst_q.any_src | rst_q.external_reset_pin | rst_q.por) begin
					next_state      = st_normal; // [R10]
					next_ctrl_a     = '0;
					next_ctrl_b     = '0;
					next_chip_reset = 1'b1;
				end
			end
			st_shutdown: begin
				// shutdown ignores the other reset sources, though stop with its nets off still exits on any_src
				if (rst_q.external_reset_pin | rst_q.por) begin
					next_state      = st_normal; // [R11]
					next_ctrl_a     = '0;
					next_ctrl_b     = '0;
					next_chip_reset = 1'b1;
				end
			end
			default: begin
				next_state = st_normal;
			end
		endcase
		next_core_clk_en   = (next_state == st_normal); // [R01] [R03]
		next_periph_clk_en = ((next_state == st_normal) || (next_state == st_idle))
			? periph_in_use : '0; // [R02] [R05] [R06]
		next_fast_osc_en   = !clocks_halted(next_state) && !nets_off(next_state); // [R07]
		next_reg_low_bias  = (next_state == st_snooze); // [R05] [R06]
		next_power_nets_on = !nets_off(next_state); // [R10]
		next_pin_hold      = nets_off(next_state); // [R12]
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state            <= st_normal;
			power_ctrl_reg_a <= '0;
			power_ctrl_reg_b <= '0;
			mode_state       <= st_normal;
			core_clk_en      <= `PMC_FLAG_ON_RST;
			periph_clk_en    <= '0;
			fast_osc_a_en    <= `PMC_FLAG_ON_RST;
			fast_osc_b_en    <= `PMC_FLAG_ON_RST;
			reg_low_bias     <= `PMC_FLAG_RST;
			power_nets_on    <= `PMC_FLAG_ON_RST;
			pin_hold         <= `PMC_FLAG_RST;
			chip_reset       <= `PMC_FLAG_RST;
			core_resume      <= `PMC_FLAG_RST;
			cmp0_prev        <= `PMC_FLAG_RST;
		end else begin
			state            <= next_state;
			power_ctrl_reg_a <= next_ctrl_a;
			power_ctrl_reg_b <= next_ctrl_b;
			mode_state       <= next_state;
			core_clk_en      <= next_core_clk_en;
			periph_clk_en    <= next_periph_clk_en;
			fast_osc_a_en    <= next_fast_osc_en;
			fast_osc_b_en    <= next_fast_osc_en;
			reg_low_bias     <= next_reg_low_bias;
			power_nets_on    <= next_power_nets_on;
			pin_hold         <= next_pin_hold;
			chip_reset       <= next_chip_reset;
			core_resume      <= next_core_resume;
			cmp0_prev        <= wake_q.cmp0_level;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	property p_normal_runs;
		(state == st_normal) |-> core_clk_en && fast_osc_a_en && power_nets_on;
	endproperty
	a_normal_runs: assert property (p_normal_runs) else $error("core not running in normal"); // [R01]

	property p_gate_unused;
		(|(periph_clk_en & ~$past(periph_in_use))) == 1'b0;
	endproperty
	a_gate_unused: assert property (p_gate_unused) else $error("unused peripheral clocked"); // [R02]

	property p_idle_entry;
		(state == st_normal) && mode_set_a.idle && !mode_set_a.stop
			&& !mode_set_b.snooze && !mode_set_b.suspend
			|=> (state == st_idle) && !core_clk_en && (periph_clk_en == $past(periph_in_use));
	endproperty
	a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong"); // [R03]

	property p_resume_no_reset;
		(state == st_idle) && irq_any
			|=> (state == st_normal) && core_clk_en && core_resume && !chip_reset;
	endproperty
	a_resume_no_reset: assert property (p_resume_no_reset) else $error("idle wake wrong"); // [R04]

	property p_suspend_bias;
		(state == st_suspend) |-> !reg_low_bias && !core_clk_en && (periph_clk_en == '0);
	endproperty
	a_suspend_bias: assert property (p_suspend_bias) else $error("suspend outputs wrong"); // [R05]

	property p_snooze_bias;
		(state == st_snooze) |-> reg_low_bias && !core_clk_en && (periph_clk_en == '0);
	endproperty
	a_snooze_bias: assert property (p_snooze_bias) else $error("snooze outputs wrong"); // [R06]

	property p_fast_osc_off;
		clocks_halted(state) |-> !fast_osc_a_en && !fast_osc_b_en;
	endproperty
	a_fast_osc_off: assert property (p_fast_osc_off) else $error("fast osc running"); // [R07]

	property p_wake_exit;
		clocks_halted(state) && wake_hit
			|=> (state == st_normal) && core_resume && fast_osc_a_en && fast_osc_b_en;
	endproperty
	a_wake_exit: assert property (p_wake_exit) else $error("missed wake event"); // [R09]

	property p_stop_exit;
		(state == st_stop) && rst_q.any_src |=> (state == st_normal) && chip_reset;
	endproperty
	a_stop_exit: assert property (p_stop_exit) else $error("stop not left on reset"); // [R10]

	property p_shutdown_hold;
		(state == st_shutdown) && !rst_q.external_reset_pin && !rst_q.por
			|=> (state == st_shutdown) && !power_nets_on;
	endproperty
	a_shutdown_hold: assert property (p_shutdown_hold) else $error("shutdown left wrongly"); // [R11]

	property p_pins_held;
		nets_off(state) |-> pin_hold && !power_nets_on && !fast_osc_b_en;
	endproperty
	a_pins_held: assert property (p_pins_held) else $error("pins not held"); // [R12]

	property p_bit_cleared;
		(state == st_suspend) ##1 (state == st_normal) |-> !power_ctrl_reg_b.suspend;
	endproperty
	a_bit_cleared: assert property (p_bit_cleared) else $error("suspend bit not cleared"); // [R13]

	property p_snooze_cleared;
		(state == st_snooze) && wake_hit |=> !power_ctrl_reg_b.snooze && core_resume;
	endproperty
	a_snooze_cleared: assert property (p_snooze_cleared) else $error("snooze bit kept"); // [R13]

	property p_idle_cleared;
		(state == st_idle) && irq_any |=> !power_ctrl_reg_a.idle;
	endproperty
	a_idle_cleared: assert property (p_idle_cleared) else $error("idle bit kept"); // [R13]

	// the core is halted off normal, so a request there is stale
	property p_refuse_off_normal;
		(state != st_normal) && mode_set_a.idle |=> (state != st_idle);
	endproperty
	a_refuse_off_normal: assert property (p_refuse_off_normal) else $error("idle taken"); // [R03]

	// one tick may still leave on the edge the nets drop
	property p_tick_halted;
		!power_nets_on && !$past(power_nets_on) |-> !timer34_tick;
	endproperty
	a_tick_halted: assert property (p_tick_halted) else $error("slow tick with nets off"); // [R10]

	c_idle_round: cover property ((state == st_idle) ##1 (state == st_normal));
	c_snooze_tick: cover property ((state == st_snooze) && timer34_tick);
	c_suspend_wake: cover property ((state == st_suspend) ##1 core_resume);
	c_shutdown_exit: cover property ((state == st_shutdown) ##1 chip_reset);

endmodule

// ==== rtl/pmc_consts.svh ====
/*
 * Constants of the power mode controller: reset values, divider ratio, widths.
 * Assumes it is included by bare name from the package and every design file.
 */
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// What this block does
// [R01] normal mode: core and peripherals clocked
// [R02] unused digital peripherals get clock gated
// [R03] idle bit halts core; interrupt wakes
// [R04] wake from idle/suspend/snooze resumes, no reset
// [R05] suspend: clocks halted, regulator normal bias
// [R06] snooze: clocks halted, regulator low bias
// [R07] suspend/snooze stop both fast oscillators
// [R08] timers 3, 4 tick from slow oscillator
// [R09] six listed events end suspend or snooze
// [R10] stop: nets off, any reset exits
// [R11] shutdown: only pin or power-on reset exits
// [R12] stop/shutdown hold every pin state
// [R13] exit clears the matching mode request bit

`define PMC_FLAG_RST     1'b0
`define PMC_FLAG_ON_RST  1'b1
`define PMC_SLOW_DIV     8
`define PMC_NUM_PERIPH   8
`define PMC_WAKE_W       6
`define PMC_RST_W        3
`define PMC_SYNC_STAGES  3

`endif

// ==== rtl/pmc_pkg.sv ====
/*
 * Types shared by the power mode controller files.
 * Assumes the constants header is on the include path.
 */
`include "pmc_consts.svh"

package pmc_pkg;

	typedef enum logic [2:0] {
		st_normal,
		st_idle,
		st_suspend,
		st_snooze,
		st_stop,
		st_shutdown
	} pmc_state_e;

	// power_ctrl_reg_a mode bits
	typedef struct packed {
		logic idle;
		logic stop;
	} pmc_ctrl_a_s;

	// power_ctrl_reg_b mode bits
	typedef struct packed {
		logic suspend;
		logic snooze;
	} pmc_ctrl_b_s;

	// wake sources of suspend and snooze
	typedef struct packed {
		logic timer4_event;
		logic serial_periph_port_act;
		logic two_wire_slave_port_act;
		logic port_match;
		logic cmp0_level;
		logic config_logic_unit_irq;
	} pmc_wake_s;

	// reset sources
	typedef struct packed {
		logic any_src;
		logic external_reset_pin;
		logic por;
	} pmc_rst_s;

endpackage

// ==== rtl/pmc_sync.sv ====
/*
 * Three-stage synchroniser; a bit's output follows once stages two and three agree.
 * Assumes inputs are asynchronous to sys_clk and held at least three cycles.
 */
`include "pmc_consts.svh"

module pmc_sync #(
	parameter int WIDTH = 1
) (
	input  logic             sys_clk,
	input  logic             srst,
	input  logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	import pmc_pkg::*;

	initial begin
		if (WIDTH < 1) begin
			$error("pmc_sync: WIDTH must be at least 1");
		end
	end

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_sync_out;

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			// stage1 is read only by stage2
			always_comb begin
				next_sync_out[gi] = (stage2[gi] == stage3[gi]) ? stage3[gi] : sync_out[gi];
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stage1   <= {WIDTH{`PMC_FLAG_RST}};
			stage2   <= {WIDTH{`PMC_FLAG_RST}};
			stage3   <= {WIDTH{`PMC_FLAG_RST}};
			sync_out <= {WIDTH{`PMC_FLAG_RST}};
		end else begin
			stage1   <= async_in;
			stage2   <= stage1;
			stage3   <= stage2;
			sync_out <= next_sync_out;
		end
	end

endmodule

// ==== rtl/pmc_slow_div.sv ====
/*
 * Divides the synchronised slow oscillator into a one-cycle tick enable.
 * Assumes slow_level is already synchronised to sys_clk.
 */
`include "pmc_consts.svh"

module pmc_slow_div #(
	parameter int DIV = `PMC_SLOW_DIV
) (
	input  logic sys_clk,
	input  logic srst,
	input  logic enable,
	input  logic slow_level,
	output logic tick
);
	import pmc_pkg::*;

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

	initial begin
		if (DIV < 1) begin
			$error("pmc_slow_div: DIV must be at least 1");
		end
	end

	logic          slow_prev;
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          next_tick;
	logic          rise;

	always_comb begin
		rise       = slow_level & ~slow_prev;
		next_count = count;
		next_tick  = 1'b0;
		if (!enable) begin
			next_count = '0;
		end else if (rise) begin
			if (count == CW'(DIV - 1)) begin
				next_count = '0;
				next_tick  = 1'b1;
			end else begin
				next_count = count + CW'(1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			slow_prev <= `PMC_FLAG_RST;
			count     <= '0;
			tick      <= `PMC_FLAG_RST;
		end else begin
			slow_prev <= slow_level;
			count     <= next_count;
			tick      <= next_tick;
		end
	end

endmodule

// ==== bench/pmc_partner_model.sv ====
/*
 * Wake-source peripherals and slow oscillator seen by the power mode controller.
 * Assumes the bench hands it wake and reset requests on sys_clk edges.
 */
module pmc_partner_model (
	input  pmc_pkg::pmc_wake_s wake_req,
	input  pmc_pkg::pmc_rst_s  rst_req,
	output pmc_pkg::pmc_wake_s wake_src,
	output pmc_pkg::pmc_rst_s  rst_src,
	output logic               slow_osc
);
	timeunit 1ns;
	timeprecision 1ps;
	import pmc_pkg::*;

	// pins move off the clock edge, as real async sources do
	assign #3 wake_src = wake_req;
	assign #3 rst_src  = rst_req;

	// slow oscillator runs free, also in suspend and snooze
	initial begin
		slow_osc = 1'b0;
	end
	always #50 slow_osc = ~slow_osc;
endmodule

// ==== bench/tb_pmc_power_mode_controller.sv ====
/*
 * Self-checking bench of the power mode controller: row table of mode entries and
 * exits, then wake sources, refused requests, slow tick and shutdown exit.
 * Assumes the package and design files are compiled first.
 */
module tb_pmc_power_mode_controller;
	timeunit 1ns;
	timeprecision 1ps;
	import pmc_pkg::*;

	typedef struct packed {
		pmc_ctrl_a_s a;
		pmc_ctrl_b_s b;
		logic        sd;
		pmc_state_e  st;
		logic [5:0]  ctl;
		logic        irq;
		pmc_wake_s   wake;
		pmc_rst_s    rst;
		logic        res;
	} pmc_tb_row_s;

	// comparator output idles high so a drop is the wake edge
	localparam pmc_wake_s WAKE_IDLE = 6'h02;

	logic        sys_clk;
	logic        srst;
	pmc_ctrl_a_s mode_set_a;
	pmc_ctrl_b_s mode_set_b;
	logic        shutdown_select_bit;
	logic        irq_any;
	logic [7:0]  periph_in_use;
	logic        timer34_slow_sel;
	logic        slow_osc;
	pmc_wake_s   wake_req;
	pmc_wake_s   wake_src;
	pmc_rst_s    rst_req;
	pmc_rst_s    rst_src;
	pmc_ctrl_a_s power_ctrl_reg_a;
	pmc_ctrl_b_s power_ctrl_reg_b;
	pmc_state_e  mode_state;
	logic        core_clk_en;
	logic [7:0]  periph_clk_en;
	logic        timer34_tick;
	logic        fast_osc_a_en;
	logic        fast_osc_b_en;
	logic        reg_low_bias;
	logic        power_nets_on;
	logic        pin_hold;
	logic        chip_reset;
	logic        core_resume;
	logic [5:0]  ctl;
	logic [15:0] outs;
	int          failures;
	int          checks;
	pmc_tb_row_s rows [5];

	assign ctl = {core_clk_en, fast_osc_a_en, fast_osc_b_en, reg_low_bias, power_nets_on, pin_hold};
	assign outs = {4'h0, ctl, core_resume, chip_reset, power_ctrl_reg_a, power_ctrl_reg_b};

	pmc_power_mode_controller #(.NUM_PERIPH(8), .SLOW_DIV(2)) i_pmc_power_mode_controller (
		.sys_clk(sys_clk), .srst(srst), .mode_set_a(mode_set_a), .mode_set_b(mode_set_b),
		.shutdown_select_bit(shutdown_select_bit), .irq_any(irq_any),
		.periph_in_use(periph_in_use), .timer34_slow_sel(timer34_slow_sel),
		.slow_osc(slow_osc), .wake_src(wake_src), .rst_src(rst_src),
		.power_ctrl_reg_a(power_ctrl_reg_a), .power_ctrl_reg_b(power_ctrl_reg_b),
		.mode_state(mode_state), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
		.timer34_tick(timer34_tick), .fast_osc_a_en(fast_osc_a_en),
		.fast_osc_b_en(fast_osc_b_en), .reg_low_bias(reg_low_bias),
		.power_nets_on(power_nets_on), .pin_hold(pin_hold), .chip_reset(chip_reset),
		.core_resume(core_resume)
	);

	pmc_partner_model i_pmc_partner_model (
		.wake_req(wake_req), .rst_req(rst_req), .wake_src(wake_src),
		.rst_src(rst_src), .slow_osc(slow_osc)
	);

	always #4 sys_clk = ~sys_clk;

	task automatic chk_state(input pmc_state_e got, input pmc_state_e exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bits(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// select bit goes one cycle ahead of the mode pulse, as software must do it
	task automatic enter(input pmc_ctrl_a_s a, input pmc_ctrl_b_s b, input logic sd);
		@(posedge sys_clk);
		shutdown_select_bit <= sd;
		@(posedge sys_clk);
		mode_set_a <= a;
		mode_set_b <= b;
		@(posedge sys_clk);
		mode_set_a <= '0;
		mode_set_b <= '0;
		#1;
	endtask

	// async wakes need the synchroniser, so poll a bounded span
	task automatic wait_normal();
		int n = 0;
		while (mode_state !== st_normal && n < 16) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk_state(mode_state, st_normal);
	endtask

	task automatic release_all();
		@(posedge sys_clk);
		irq_any <= 1'b0;
		wake_req <= WAKE_IDLE;
		rst_req <= '0;
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic end_sim();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		int n;
		rows[0] = '{2'b10, 2'b00, 1'b0, st_idle, 6'h1a, 1'b1, WAKE_IDLE, 3'b000, 1'b1};
		rows[1] = '{2'b00, 2'b10, 1'b0, st_suspend, 6'h02, 1'b0, 6'h22, 3'b000, 1'b1};
		rows[2] = '{2'b00, 2'b01, 1'b0, st_snooze, 6'h06, 1'b0, 6'h12, 3'b000, 1'b1};
		rows[3] = '{2'b01, 2'b00, 1'b0, st_stop, 6'h01, 1'b0, WAKE_IDLE, 3'b100, 1'b0};
		rows[4] = '{2'b01, 2'b00, 1'b1, st_shutdown, 6'h01, 1'b0, WAKE_IDLE, 3'b010, 1'b0};
		failures = 0;
		checks = 0;
		sys_clk = 1'b0;
		srst = 1'b1;
		mode_set_a = '0;
		mode_set_b = '0;
		shutdown_select_bit = 1'b0;
		irq_any = 1'b0;
		periph_in_use = 8'h00;
		timer34_slow_sel = 1'b1;
		wake_req = WAKE_IDLE;
		rst_req = '0;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk_state(mode_state, st_normal);
		chk_bits(outs, {4'h0, 6'h3a, 6'h00});

		foreach (rows[i]) begin
			enter(rows[i].a, rows[i].b, rows[i].sd);
			chk_state(mode_state, rows[i].st);
			chk_bits({10'h0, ctl}, {10'h0, rows[i].ctl});
			@(posedge sys_clk);
			irq_any <= rows[i].irq;
			wake_req <= rows[i].wake;
			rst_req <= rows[i].rst;
			wait_normal();
			chk_bits(outs, {4'h0, 6'h3a, rows[i].res, ~rows[i].res, 4'h0});
			release_all();
		end

		for (int i = 0; i < 6; i++) begin
			enter(2'b00, 2'b01, 1'b0);
			@(posedge sys_clk);
			wake_req <= pmc_wake_s'(WAKE_IDLE ^ (6'h01 << i));
			wait_normal();
			release_all();
		end

		@(posedge sys_clk);
		periph_in_use <= 8'h5a;
		repeat (2) @(posedge sys_clk);
		#1;
		chk_bits({8'h0, periph_clk_en}, {8'h0, 8'h5a});
		enter(2'b00, 2'b10, 1'b0);
		// idle request while suspended must be ignored
		@(posedge sys_clk);
		mode_set_a <= 2'b10;
		@(posedge sys_clk);
		mode_set_a <= '0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk_state(mode_state, st_suspend);
		chk_bits({6'h0, periph_clk_en, power_ctrl_reg_a}, 16'h0);
		n = 0;
		repeat (120) begin
			@(posedge sys_clk);
			#1;
			if (timer34_tick === 1'b1) n++;
		end
		// 960 ns of a 100 ns slow clock divided by two
		chk_bits({15'h0, n >= 4 && n <= 5}, 16'h1);
		// deselected slow source must leave the timers still
		@(posedge sys_clk);
		timer34_slow_sel <= 1'b0;
		n = 0;
		repeat (40) begin
			@(posedge sys_clk);
			#1;
			if (timer34_tick === 1'b1) n++;
		end
		chk_bits(16'(n), 16'h0);
		@(posedge sys_clk);
		timer34_slow_sel <= 1'b1;
		@(posedge sys_clk);
		wake_req <= 6'h06;
		wait_normal();
		release_all();

		enter(2'b01, 2'b00, 1'b1);
		@(posedge sys_clk);
		rst_req <= 3'b100;
		repeat (10) @(posedge sys_clk);
		#1;
		chk_state(mode_state, st_shutdown);
		@(posedge sys_clk);
		rst_req <= 3'b101;
		wait_normal();
		chk_bits({15'h0, chip_reset}, 16'h1);
		release_all();
		// reset in mid-snooze brings back the normal outputs at once
		enter(2'b00, 2'b01, 1'b0);
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk_state(mode_state, st_normal);
		chk_bits(outs, {4'h0, 6'h3a, 6'h00});
		end_sim();
	end

	// whole sequence takes well under a thousand cycles
	initial begin
		#(8 * 4000);
		failures++;
		end_sim();
	end
endmodule
